// ==== src/hsdp_pkg.sv ====
// Shared constants and types for the hall switch parameter and lock block
package hsdp_pkg;
   // -------------------------------------------------------------
   // Widths
   // -------------------------------------------------------------
   localparam int SAMPLE_W = 14;
   localparam int GAIN_W = 14;
   localparam int GAIN_FRAC = 11;
   localparam int PROD_W = 28;
   localparam int OFFSET_W = 11;
   localparam int LOW_W = 11;
   localparam int HIGH_W = 12;
   localparam int MODE_W = 8;
   localparam int COEF_LIN_W = 8;
   localparam int COEF_SQ_W = 8;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int SIG_W = 18;
   localparam int CNT_W = 5;
   // -------------------------------------------------------------
   // Command indices of the parameter registers
   // -------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_COEF_LIN = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_COEF_SQ = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_GAIN = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_LOW = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_HIGH = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_LOCK = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_READOUT = 4'h8;
   // -------------------------------------------------------------
   // Scaling and values after reset
   // -------------------------------------------------------------
   localparam logic [SIG_W-1:0] SIG_FULL_SCALE = 18'h00800; // Supply value
   localparam logic [GAIN_W-1:0] RST_GAIN = 14'h0800; // Gain of one
   localparam logic [OFFSET_W-1:0] RST_OFFSET = 11'h000;
   localparam logic [LOW_W-1:0] RST_LOW = 11'h200;
   localparam logic [HIGH_W-1:0] RST_HIGH = 12'h400;
   localparam logic [MODE_W-1:0] RST_MODE = 8'h00;
   localparam logic [COEF_LIN_W-1:0] RST_COEF_LIN = 8'h00;
   localparam logic [COEF_SQ_W-1:0] RST_COEF_SQ = 8'h00;
   localparam logic [CNT_W-1:0] ANS_READ_BITS = 5'h10;
   localparam logic [CNT_W-1:0] ANS_ACK_BITS = 5'h01;
   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_ANSWER = 1'b1} hsdp_state_type;
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } hsdp_cmd_type;
   typedef struct packed {
      logic [GAIN_W-1:0] gain;
      logic [OFFSET_W-1:0] offset;
      logic [LOW_W-1:0] low;
      logic [HIGH_W-1:0] high;
   } hsdp_params_type;
endpackage

// ==== src/hsdp_dsp.sv ====
// Gain, offset, upper limit and hysteresis comparator
`timescale 1ns/1ps
module hsdp_dsp (
   input wire logic clk, // 40 MHz clock
   input wire logic rst, // Synchronous reset
   input wire logic ce, // Clock enable
   input wire logic [hsdp_pkg::SAMPLE_W-1:0] sample, // Signed field sample
   input wire logic sample_valid, // New sample strobe
   input wire hsdp_pkg::hsdp_params_type params, // Processing parameters
   output logic [hsdp_pkg::SIG_W-1:0] proc_sig_ff, // Processed signal
   output logic switch_ff // Comparator output, low = on
);
   // -------------------------------------------------------------
   // Arithmetic
   // -------------------------------------------------------------
   logic signed [hsdp_pkg::PROD_W-1:0] prod;
   logic signed [hsdp_pkg::SIG_W-1:0] scaled;
   logic signed [hsdp_pkg::SIG_W-1:0] off2;
   logic signed [hsdp_pkg::SIG_W-1:0] sum;
   logic signed [hsdp_pkg::SIG_W-1:0] limit;
   logic signed [hsdp_pkg::SIG_W-1:0] nxt_proc;
   logic signed [hsdp_pkg::SIG_W-1:0] low_s;
   logic signed [hsdp_pkg::SIG_W-1:0] high_s;

   // Scale sample by gain, gain of one maps 2048 counts to full scale
   assign prod = $signed(sample) * $signed(params.gain);
   assign scaled = {prod[hsdp_pkg::PROD_W-1], prod[hsdp_pkg::PROD_W-1:hsdp_pkg::GAIN_FRAC]};
   // Offset counts are twice the signal step
   assign off2 = {{6{params.offset[hsdp_pkg::OFFSET_W-1]}}, params.offset, 1'b0};
   assign sum = scaled + off2;
   // Negative offset lowers the ceiling by the same amount
   assign limit = params.offset[hsdp_pkg::OFFSET_W-1] ?
                  $signed(hsdp_pkg::SIG_FULL_SCALE) + off2 :
                  $signed(hsdp_pkg::SIG_FULL_SCALE);
   assign nxt_proc = (sum > limit) ? limit : sum;
   assign low_s = $signed({7'h00, params.low});
   assign high_s = $signed({6'h00, params.high});

   // Processed signal register
   always_ff @(posedge clk) begin
      if (rst) begin
         proc_sig_ff <= '0;
      end else if (ce && sample_valid) begin
         proc_sig_ff <= nxt_proc;
      end
   end

   // Hysteresis comparator
   always_ff @(posedge clk) begin
      if (rst) begin
         switch_ff <= 1'b1;
      end else if (ce) begin
         if ($signed(proc_sig_ff) > high_s) begin
            switch_ff <= 1'b0;
         end else if ($signed(proc_sig_ff) < low_s) begin
            switch_ff <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   property p_zero_field;
      @(posedge clk) disable iff (rst)
      (ce && sample_valid && sample == '0 && !params.offset[hsdp_pkg::OFFSET_W-1])
      |=> $signed(proc_sig_ff) == $past(off2);
   endproperty
   a_zero_field: assert property (p_zero_field) else $error("zero field not offset");
   property p_ceiling;
      @(posedge clk) disable iff (rst)
      (ce && sample_valid) |=> $signed(proc_sig_ff) <= $past(limit);
   endproperty
   a_ceiling: assert property (p_ceiling) else $error("ceiling exceeded");
   property p_unit_gain;
      @(posedge clk) disable iff (rst)
      (ce && sample_valid && params.gain == hsdp_pkg::RST_GAIN && params.offset == '0
       && sample == 14'h0800) |=> proc_sig_ff == hsdp_pkg::SIG_FULL_SCALE;
   endproperty
   a_unit_gain: assert property (p_unit_gain) else $error("unit gain wrong");
   property p_switch_on;
      @(posedge clk) disable iff (rst)
      (ce && $signed(proc_sig_ff) > high_s) |=> !switch_ff;
   endproperty
   a_switch_on: assert property (p_switch_on) else $error("no switch on");
   property p_hold;
      @(posedge clk) disable iff (rst)
      ($signed(proc_sig_ff) <= high_s && $signed(proc_sig_ff) >= low_s) |=> $stable(switch_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("hysteresis not held");
endmodule // hsdp_dsp

// ==== src/hsdp_top.sv ====
// Parameter registers, permanent lock and command answer of the hall switch
// -------------------------------------------------------------
// Overview of operation
// - Add programmed offset to scaled sample
// - Zero sample gives exactly the offset
// - Negative offset lowers the signal ceiling
// - Switch-off threshold zero to full supply
// - Switch-on threshold zero to twice supply
// - Lock freezes registers and ignores communication
// - Lock effective only after next power cycle
// - Nothing ever clears the lock bit
// - Filtered 14-bit sample is readable
// - Locked device answers no command
// - Sample signed, positive means north
// - Output low above on, high below off
// - Gain spans four, unity maps 2048 counts
// - Output pin answers during communication on an unlocked device
// -------------------------------------------------------------
`timescale 1ns/1ps
module hsdp_top (
   input wire logic clk, // 40 MHz clock
   input wire logic rst, // Synchronous power-on reset
   input wire logic ce, // Clock enable
   input wire logic [hsdp_pkg::SAMPLE_W-1:0] sample_in, // Filtered signed sample
   input wire logic sample_valid, // Sample strobe
   input wire logic comm_active, // Supply-modulation exchange in progress
   input wire logic cmd_valid, // Decoded command strobe
   input wire hsdp_pkg::hsdp_cmd_type cmd, // Decoded command
   input wire logic nv_lock_in, // Stored lock bit from nonvolatile cell
   output logic nv_lock_prog, // Pulse programming the lock cell
   output logic device_locked, // Lock in effect this session
   output logic out_pin // Switch output or answer bit
);
   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   hsdp_pkg::hsdp_state_type state_ff;
   hsdp_pkg::hsdp_params_type params_ff;
   logic [hsdp_pkg::MODE_W-1:0] mode_ff;
   logic [hsdp_pkg::COEF_LIN_W-1:0] temp_coeff_linear_ff;
   logic [hsdp_pkg::COEF_SQ_W-1:0] temp_coeff_quadratic_ff;
   logic [hsdp_pkg::SAMPLE_W-1:0] readout_ff;
   logic permanent_lock_ff;
   logic locked_ff;
   logic nv_lock_prog_ff;
   logic [hsdp_pkg::DATA_W-1:0] ans_shift_ff;
   logic [hsdp_pkg::CNT_W-1:0] ans_cnt_ff;
   logic [hsdp_pkg::SIG_W-1:0] proc_sig;
   logic switch_lvl;
   logic accept;
   logic do_write;
   logic [hsdp_pkg::DATA_W-1:0] wd;

   // -------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------
   // Register that the programmer may write
   function automatic logic reg_writable(input logic [hsdp_pkg::ADDR_W-1:0] a);
      reg_writable = (a <= hsdp_pkg::ADDR_LOCK);
   endfunction

   // Read data of one register
   function automatic logic [hsdp_pkg::DATA_W-1:0] reg_read(
      input logic [hsdp_pkg::ADDR_W-1:0] a
   );
      logic [hsdp_pkg::DATA_W-1:0] r;
      r = '0;
      if (a == hsdp_pkg::ADDR_MODE) begin
         r = {8'h00, mode_ff};
      end else if (a == hsdp_pkg::ADDR_COEF_LIN) begin
         r = {8'h00, temp_coeff_linear_ff};
      end else if (a == hsdp_pkg::ADDR_COEF_SQ) begin
         r = {8'h00, temp_coeff_quadratic_ff};
      end else if (a == hsdp_pkg::ADDR_GAIN) begin
         r = {{2{params_ff.gain[hsdp_pkg::GAIN_W-1]}}, params_ff.gain};
      end else if (a == hsdp_pkg::ADDR_OFFSET) begin
         r = {{5{params_ff.offset[hsdp_pkg::OFFSET_W-1]}}, params_ff.offset};
      end else if (a == hsdp_pkg::ADDR_LOW) begin
         r = {5'h00, params_ff.low};
      end else if (a == hsdp_pkg::ADDR_HIGH) begin
         r = {4'h0, params_ff.high};
      end else if (a == hsdp_pkg::ADDR_LOCK) begin
         r = {15'h0000, permanent_lock_ff};
      end else if (a == hsdp_pkg::ADDR_READOUT) begin
         r = {{2{readout_ff[hsdp_pkg::SAMPLE_W-1]}}, readout_ff};
      end
      reg_read = r;
   endfunction

   // Commands are taken only when idle and not locked
   assign accept = ce && cmd_valid && !locked_ff && (state_ff == hsdp_pkg::ST_IDLE);
   assign do_write = accept && cmd.write && reg_writable(cmd.addr);
   assign wd = cmd.wdata;

   // -------------------------------------------------------------
   // Lock handling
   // -------------------------------------------------------------
   // Session lock taken from the stored bit at reset only
   always_ff @(posedge clk) begin
      if (rst) begin
         locked_ff <= nv_lock_in;
      end
   end

   // Lock bit, write one to set, survives reset
   always_ff @(posedge clk) begin
      if (rst) begin
         // Cell value, or a programming pulse still under way, keeps it set
         permanent_lock_ff <= nv_lock_in | nv_lock_prog_ff;
      end else if (ce && do_write && cmd.addr == hsdp_pkg::ADDR_LOCK && wd[0]) begin
         permanent_lock_ff <= 1'b1;
      end
   end

   // Programming pulse for the nonvolatile lock cell
   always_ff @(posedge clk) begin
      if (rst) begin
         nv_lock_prog_ff <= 1'b0;
      end else if (ce) begin
         nv_lock_prog_ff <= do_write && cmd.addr == hsdp_pkg::ADDR_LOCK && wd[0];
      end
   end

   // -------------------------------------------------------------
   // Parameter registers
   // -------------------------------------------------------------
   // Mode and temperature coefficients
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_ff <= hsdp_pkg::RST_MODE;
         temp_coeff_linear_ff <= hsdp_pkg::RST_COEF_LIN;
         temp_coeff_quadratic_ff <= hsdp_pkg::RST_COEF_SQ;
      end else if (do_write) begin
         if (cmd.addr == hsdp_pkg::ADDR_MODE) begin
            mode_ff <= wd[hsdp_pkg::MODE_W-1:0];
         end else if (cmd.addr == hsdp_pkg::ADDR_COEF_LIN) begin
            temp_coeff_linear_ff <= wd[hsdp_pkg::COEF_LIN_W-1:0];
         end else if (cmd.addr == hsdp_pkg::ADDR_COEF_SQ) begin
            temp_coeff_quadratic_ff <= wd[hsdp_pkg::COEF_SQ_W-1:0];
         end
      end
   end

   // Gain, offset and comparator thresholds
   always_ff @(posedge clk) begin
      if (rst) begin
         params_ff.gain <= hsdp_pkg::RST_GAIN;
         params_ff.offset <= hsdp_pkg::RST_OFFSET;
         params_ff.low <= hsdp_pkg::RST_LOW;
         params_ff.high <= hsdp_pkg::RST_HIGH;
      end else if (do_write) begin
         if (cmd.addr == hsdp_pkg::ADDR_GAIN) begin
            params_ff.gain <= wd[hsdp_pkg::GAIN_W-1:0];
         end else if (cmd.addr == hsdp_pkg::ADDR_OFFSET) begin
            params_ff.offset <= wd[hsdp_pkg::OFFSET_W-1:0];
         end else if (cmd.addr == hsdp_pkg::ADDR_LOW) begin
            params_ff.low <= wd[hsdp_pkg::LOW_W-1:0];
         end else if (cmd.addr == hsdp_pkg::ADDR_HIGH) begin
            params_ff.high <= wd[hsdp_pkg::HIGH_W-1:0];
         end
      end
   end

   // Sample readout for calibration
   always_ff @(posedge clk) begin
      if (rst) begin
         readout_ff <= '0;
      end else if (ce && sample_valid) begin
         readout_ff <= sample_in;
      end
   end

   // -------------------------------------------------------------
   // Answer on the output pin
   // -------------------------------------------------------------
   // Serial answer, MSB first, one bit per enabled cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= hsdp_pkg::ST_IDLE;
         ans_shift_ff <= '0;
         ans_cnt_ff <= '0;
      end else if (ce) begin
         case (state_ff)
            hsdp_pkg::ST_IDLE: begin
               if (accept) begin
                  state_ff <= hsdp_pkg::ST_ANSWER;
                  if (cmd.write) begin
                     ans_shift_ff <= {reg_writable(cmd.addr), 15'h0000};
                     ans_cnt_ff <= hsdp_pkg::ANS_ACK_BITS;
                  end else begin
                     ans_shift_ff <= reg_read(cmd.addr);
                     ans_cnt_ff <= hsdp_pkg::ANS_READ_BITS;
                  end
               end
            end
            hsdp_pkg::ST_ANSWER: begin
               ans_shift_ff <= {ans_shift_ff[hsdp_pkg::DATA_W-2:0], 1'b0};
               ans_cnt_ff <= ans_cnt_ff - 5'h01;
               if (ans_cnt_ff == 5'h01) begin
                  state_ff <= hsdp_pkg::ST_IDLE;
               end
            end
            default: begin
               state_ff <= hsdp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Signal processing
   // -------------------------------------------------------------
   hsdp_dsp u_dsp (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .sample(sample_in),
      .sample_valid(sample_valid),
      .params(params_ff),
      .proc_sig_ff(proc_sig),
      .switch_ff(switch_lvl)
   );

   // Output pin carries the answer while an exchange runs on an unlocked device
   always_comb begin
      if (comm_active && !locked_ff) begin
         out_pin = (state_ff == hsdp_pkg::ST_ANSWER) ? ans_shift_ff[15] : 1'b1;
      end else begin
         out_pin = switch_lvl;
      end
   end

   assign nv_lock_prog = nv_lock_prog_ff;
   assign device_locked = locked_ff;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   sequence s_lock_write;
      accept && cmd.write && cmd.addr == hsdp_pkg::ADDR_LOCK && cmd.wdata[0];
   endsequence
   sequence s_read_accept;
      accept && !cmd.write;
   endsequence
   sequence s_answer_16;
      state_ff == hsdp_pkg::ST_ANSWER ##16 state_ff == hsdp_pkg::ST_IDLE;
   endsequence

   property p_frozen;
      @(posedge clk) disable iff (rst)
      locked_ff |=> $stable(params_ff) && $stable(mode_ff) && $stable(temp_coeff_linear_ff);
   endproperty
   a_frozen: assert property (p_frozen) else $error("locked register changed");
   property p_no_answer;
      @(posedge clk) disable iff (rst)
      locked_ff |-> state_ff == hsdp_pkg::ST_IDLE && out_pin == switch_lvl;
   endproperty
   a_no_answer: assert property (p_no_answer) else $error("locked device answered");
   property p_lock_deferred;
      @(posedge clk) disable iff (rst)
      s_lock_write ##0 !locked_ff |=> !locked_ff ##0 permanent_lock_ff;
   endproperty
   a_lock_deferred: assert property (p_lock_deferred) else $error("lock acted early");
   property p_lock_sticky;
      @(posedge clk) disable iff (rst)
      permanent_lock_ff |=> permanent_lock_ff;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
   property p_session;
      @(posedge clk) disable iff (rst)
      1'b1 |=> $stable(locked_ff);
   endproperty
   a_session: assert property (p_session) else $error("session lock moved");
   property p_readout;
      @(posedge clk) disable iff (rst)
      (ce && sample_valid) |=> readout_ff == $past(sample_in);
   endproperty
   a_readout: assert property (p_readout) else $error("readout not captured");
   property p_read_len;
      @(posedge clk) disable iff (rst || !ce)
      s_read_accept |=> s_answer_16;
   endproperty
   a_read_len: assert property (p_read_len) else $error("answer length wrong");
   property p_pin_answer;
      @(posedge clk) disable iff (rst)
      (comm_active && state_ff == hsdp_pkg::ST_ANSWER) |-> out_pin == ans_shift_ff[15];
   endproperty
   a_pin_answer: assert property (p_pin_answer) else $error("pin not answering");
   property p_low_store;
      @(posedge clk) disable iff (rst)
      (do_write && cmd.addr == hsdp_pkg::ADDR_LOW) |=> params_ff.low == $past(wd[10:0]);
   endproperty
   a_low_store: assert property (p_low_store) else $error("off threshold not stored");
   property p_high_store;
      @(posedge clk) disable iff (rst)
      (do_write && cmd.addr == hsdp_pkg::ADDR_HIGH) |=> params_ff.high == $past(wd[11:0]);
   endproperty
   a_high_store: assert property (p_high_store) else $error("on threshold not stored");
   property p_offset_store;
      @(posedge clk) disable iff (rst)
      (do_write && cmd.addr == hsdp_pkg::ADDR_OFFSET) |=> params_ff.offset == $past(wd[10:0]);
   endproperty
   a_offset_store: assert property (p_offset_store) else $error("offset not stored");
endmodule // hsdp_top

// ==== testbench/hsdp_prog_model.sv ====
// Programmer model: sends decoded commands and holds the lock cell
`timescale 1ns/1ps
module hsdp_prog_model (
   input wire logic clk, // System clock
   input wire logic out_pin, // Answer or switch level
   input wire logic nv_lock_prog, // Lock cell program pulse
   output logic comm_active, // Exchange in progress
   output logic cmd_valid, // Command strobe
   output hsdp_pkg::hsdp_cmd_type cmd, // Command word
   output logic nv_lock_in // Stored lock cell
);
   int prog_cnt = 0;
   // Idle levels at time zero
   initial begin
      comm_active = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      nv_lock_in = 1'b0;
   end
   // Lock cell keeps its value across power cycles, programmed once only
   always @(posedge clk) begin
      if (nv_lock_prog) begin
         nv_lock_in <= 1'b1;
         prog_cnt <= prog_cnt + 1;
      end
   end
   // One exchange: command taken, then answer bits collected MSB first
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      int n;
      n = wr ? 1 : 16;
      q = '0;
      @(negedge clk);
      comm_active = 1'b1;
      cmd_valid = 1'b1;
      cmd = '{write: wr, addr: a, wdata: d};
      @(posedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd = {~wr, ~a, ~d}; // Released lines no longer show the command
      q = {q[14:0], out_pin};
      for (int i = 1; i < n; i++) begin
         @(posedge clk);
         @(negedge clk);
         q = {q[14:0], out_pin};
      end
      @(posedge clk);
      @(negedge clk);
      comm_active = 1'b0;
   endtask
endmodule // hsdp_prog_model

// ==== testbench/tb.sv ====
// Self-checking bench for the parameter, lock and comparator block
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [13:0] sample_in = '0;
   logic sample_valid = 1'b0;
   logic ce = 1'b1;
   logic comm_active, cmd_valid, nv_lock_in, nv_lock_prog, device_locked, out_pin;
   hsdp_pkg::hsdp_cmd_type cmd;
   logic [15:0] q;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   // -------------------------------------------------------------
   // Design, programmer, clock and run limit
   // -------------------------------------------------------------
   hsdp_top dut (.clk(clk), .rst(rst), .ce(ce), .sample_in(sample_in),
      .sample_valid(sample_valid), .comm_active(comm_active), .cmd_valid(cmd_valid),
      .cmd(cmd), .nv_lock_in(nv_lock_in), .nv_lock_prog(nv_lock_prog),
      .device_locked(device_locked), .out_pin(out_pin));
   hsdp_prog_model prog (.clk(clk), .out_pin(out_pin), .nv_lock_prog(nv_lock_prog),
      .comm_active(comm_active), .cmd_valid(cmd_valid), .cmd(cmd), .nv_lock_in(nv_lock_in));
   always #12.5 clk = ~clk;
   // Cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Power cycle: reset held for 8 cycles
   task automatic power_cycle();
      @(negedge clk);
      rst = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
   endtask
   // One sample, then the comparator level once settled
   task automatic feed(input logic [13:0] s, input logic exp);
      @(negedge clk);
      sample_in = s;
      sample_valid = 1'b1;
      @(negedge clk);
      sample_valid = 1'b0;
      repeat (2) @(negedge clk);
      check(out_pin, exp);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      prog.xfer(1'b0, a, 16'h0000, q);
      check(q, exp);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic ack);
      prog.xfer(1'b1, a, d, q);
      check(q[0], ack);
   endtask
   task automatic t_defaults();
      logic [15:0] rv [8] = '{16'h0, 16'h0, 16'h0, 16'h0800, 16'h0, 16'h0200, 16'h0400, 16'h0};
      for (int i = 0; i < 8; i++) rd(4'(i), rv[i]);
      rd(4'h9, 16'h0000);
      wr(hsdp_pkg::ADDR_READOUT, 16'h1234, 1'b0);
      wr(4'hf, 16'h1234, 1'b0);
   endtask
   task automatic t_common();
      wr(hsdp_pkg::ADDR_MODE, 16'h0040, 1'b1);
      wr(hsdp_pkg::ADDR_COEF_LIN, 16'h0006, 1'b1);
      wr(hsdp_pkg::ADDR_COEF_SQ, 16'h000e, 1'b1);
      rd(hsdp_pkg::ADDR_COEF_SQ, 16'h000e);
   endtask
   task automatic t_readout();
      feed(14'h3ffb, 1'b1);
      rd(hsdp_pkg::ADDR_READOUT, 16'hfffb);
      feed(14'h0abc, 1'b0);
      rd(hsdp_pkg::ADDR_READOUT, 16'h0abc);
   endtask
   task automatic t_zero();
      wr(hsdp_pkg::ADDR_OFFSET, 16'h0180, 1'b1);
      wr(hsdp_pkg::ADDR_HIGH, 16'h0300, 1'b1);
      wr(hsdp_pkg::ADDR_LOW, 16'h0301, 1'b1);
      feed(14'h0000, 1'b1);
      wr(hsdp_pkg::ADDR_HIGH, 16'h02ff, 1'b1);
      feed(14'h0000, 1'b0);
      rd(hsdp_pkg::ADDR_LOW, 16'h0301);
   endtask
   task automatic t_gain();
      wr(hsdp_pkg::ADDR_OFFSET, 16'h0000, 1'b1);
      wr(hsdp_pkg::ADDR_LOW, 16'h0100, 1'b1);
      wr(hsdp_pkg::ADDR_HIGH, 16'h0200, 1'b1);
      wr(hsdp_pkg::ADDR_GAIN, 16'h1000, 1'b1);
      feed(14'h0101, 1'b0);
      feed(14'h0100, 1'b0);
      feed(14'h007f, 1'b1);
      wr(hsdp_pkg::ADDR_GAIN, 16'hf800, 1'b1);
      feed(14'h3dff, 1'b0);
      rd(hsdp_pkg::ADDR_GAIN, 16'hf800);
   endtask
   task automatic t_clamp();
      wr(hsdp_pkg::ADDR_GAIN, 16'h0800, 1'b1);
      feed(14'h0800, 1'b0);
      wr(hsdp_pkg::ADDR_OFFSET, 16'hff00, 1'b1);
      wr(hsdp_pkg::ADDR_HIGH, 16'h0600, 1'b1);
      feed(14'h0000, 1'b1);
      feed(14'h1fff, 1'b1);
      wr(hsdp_pkg::ADDR_HIGH, 16'h05ff, 1'b1);
      feed(14'h1fff, 1'b0);
   endtask
   // Two-point calibration at full hysteresis from captured samples
   task automatic t_calib();
      logic [15:0] b_off, b_on;
      feed(14'h0100, 1'b1);
      prog.xfer(1'b0, hsdp_pkg::ADDR_READOUT, 16'h0000, b_off);
      feed(14'h0300, 1'b1);
      prog.xfer(1'b0, hsdp_pkg::ADDR_READOUT, 16'h0000, b_on);
      check(b_off, 16'h0100);
      check(b_on, 16'h0300);
      wr(hsdp_pkg::ADDR_OFFSET, 16'h0000, 1'b1);
      wr(hsdp_pkg::ADDR_LOW, b_off + 16'h0001, 1'b1);
      wr(hsdp_pkg::ADDR_HIGH, b_on - 16'h0001, 1'b1);
      feed(14'h0300, 1'b0);
      feed(14'h0200, 1'b0);
      feed(14'h0100, 1'b1);
   endtask
   // Clock enable low: sample ignored, state kept
   task automatic t_freeze();
      ce = 1'b0;
      feed(14'h0300, 1'b1);
      ce = 1'b1;
      rd(hsdp_pkg::ADDR_READOUT, 16'h0100);
   endtask
   task automatic t_lock();
      wr(hsdp_pkg::ADDR_LOCK, 16'h0001, 1'b1);
      check(16'(prog.prog_cnt), 16'h0001);
      rd(hsdp_pkg::ADDR_LOCK, 16'h0001);
      check(device_locked, 1'b0);
      wr(hsdp_pkg::ADDR_MODE, 16'h0042, 1'b1);
      rd(hsdp_pkg::ADDR_MODE, 16'h0042);
      power_cycle();
      check(device_locked, 1'b1);
      rd(hsdp_pkg::ADDR_MODE, 16'hffff);
      wr(hsdp_pkg::ADDR_GAIN, 16'h1000, 1'b1);
      feed(14'h0201, 1'b1);
      power_cycle();
      check(device_locked, 1'b1);
   endtask
   // Main sequence in calibration order, lock last
   initial begin
      power_cycle();
      t_defaults();
      t_common();
      t_readout();
      t_zero();
      t_gain();
      t_clamp();
      t_calib();
      t_freeze();
      t_lock();
      print_verdict();
   end
endmodule // tb
